//--- hdl/ifm_regs.vh
`ifndef IFM_REGS_VH
`define IFM_REGS_VH
// ****************
// register offsets
// ****************
`define IFM_ADDR_REQ0 16'hFFE0
`define IFM_ADDR_REQ1 16'hFFE1
`define IFM_ADDR_REQ2 16'hFFE2
`define IFM_ADDR_REQ3 16'hFFE3
`define IFM_ADDR_MSK0 16'hFFE4
`define IFM_ADDR_MSK1 16'hFFE5
`define IFM_ADDR_MSK2 16'hFFE6
`define IFM_ADDR_MSK3 16'hFFE7
`define IFM_ADDR_PRI0 16'hFFE8
`define IFM_ADDR_PRI1 16'hFFE9
`define IFM_ADDR_PRI2 16'hFFEA
`define IFM_ADDR_PRI3 16'hFFEB
// ****************
// reset values
// ****************
`define IFM_RST_REQ 8'h00
`define IFM_RST_MSK 8'hFF
`define IFM_RST_MSK3 8'hDF
`define IFM_RST_PRI 8'hFF
// ****************
// fixed bits
// ****************
`define IFM_REQ3_LIVE 8'h0F
`define IFM_MSK3_LIVE 8'h0F
`define IFM_MSK3_FIXED 8'hD0
`define IFM_PRI3_LIVE 8'h0F
`define IFM_PRI3_FIXED 8'hF0
`define IFM_NSRC 28
`define IFM_SHARED_BIT 10
`endif

//--- hdl/ifm_byte_reg.v
`timescale 1ns/1ns
`include "ifm_regs.vh"
// ****************
// one byte register, bit and byte writes
// ****************
module ifm_byte_reg #(
	parameter [7:0] RESET_VAL = 8'h00,
	parameter [7:0] LIVE = 8'hFF,
	parameter [7:0] FIXED = 8'h00
) (
	input wire ref_clk,
	input wire rst_n,
	input wire wr_en,
	input wire [7:0] wr_bits,
	input wire [7:0] wr_data,
	input wire [7:0] hw_set,
	input wire [7:0] hw_clr,
	output wire [7:0] value
);
	reg [7:0] q;
	reg [7:0] next_q;
	always @* begin
		next_q = q & ~hw_clr;
		if (wr_en)
			next_q = (next_q & ~wr_bits) | (wr_data & wr_bits);
		next_q = next_q | hw_set;
		next_q = (next_q & LIVE) | FIXED;
	end
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			q <= RESET_VAL;
		else
			q <= next_q;
	end
	assign value = q;
endmodule

//--- hdl/ifm_arbiter.v
`timescale 1ns/1ns
`include "ifm_regs.vh"
// ****************
// pick among eligible sources: high level (priority bit 0) first, then fixed order
// ****************
module ifm_arbiter #(
	parameter N = 28
) (
	input wire [N-1:0] eligible,
	input wire [N-1:0] prio,
	output reg found,
	output reg [4:0] index
);
	integer i;
	reg done_hi;
	always @* begin
		found = 1'b0;
		index = 5'h00;
		done_hi = 1'b0;
		// high level (priority bit 0) first, then default order
		for (i = N-1; i >= 0; i = i - 1) begin
			if (eligible[i] && !prio[i]) begin
				found = 1'b1;
				index = i[4:0];
				done_hi = 1'b1;
			end
		end
		if (!done_hi) begin
			for (i = N-1; i >= 0; i = i - 1) begin
				if (eligible[i]) begin
					found = 1'b1;
					index = i[4:0];
				end
			end
		end
	end
endmodule

//--- hdl/ifm_bank.v
`timescale 1ns/1ns
`include "ifm_regs.vh"
// How it works
// - a source pulse sets its flag; it stays set until cleared
// - cpu writing one to a flag sets it like a hardware event
// - core acknowledge clears the matching flag automatically
// - reset clears all four flag bytes
// - flags take bit and byte writes; pairs read as 16-bit words
// - flag zero means none pending, one means pending
// - byte 0: low voltage, pins 0-5, serial6 receive error
// - byte 1: serial6 rx, tx, shared csi/uart, five timers
// - byte 2: a/d, serial0 rx, watch interval, timer51, key, watch, pins 6-7
// - flag byte 3 upper nibble reads zero; software writes zero
// - mask byte 0 maps to same sources as flag byte 0
// - mask zero allows service, one blocks; flag still latches
// - masks take bit, byte and 16-bit pair writes
// - first three mask bytes reset to all ones
// - mask byte 3 resets DFH; fixed bits 7-4 hold 1,1,0,1
// - priority bits set levels; bit, byte and pair writes
// - all priority bytes reset to all ones
// - shared flag sets on src_event bit 10 or on either of its two sources
// - eligible only when flag is one and mask zero
// - equal level ties go to lowest default number
module ifm_bank (
	input wire ref_clk,
	input wire rst_n,
	input wire [27:0] src_event,
	input wire clocked_serial10_event,
	input wire uart0_transmit_event,
	input wire ack_valid,
	input wire [4:0] ack_index,
	input wire mem_wr,
	input wire mem_rd,
	input wire [15:0] mem_addr,
	input wire mem_word,
	input wire mem_bit,
	input wire [2:0] mem_bit_pos,
	input wire [15:0] mem_wdata,
	output reg [15:0] mem_rdata,
	output reg irq_pending,
	output reg [4:0] irq_index,
	output reg irq_level
);
	// ****************
	// source routing, ack clears
	// ****************
	reg [27:0] set_vec;
	reg [27:0] clr_vec;
	integer k;
	always @* begin
		set_vec = src_event;
		set_vec[`IFM_SHARED_BIT] = src_event[`IFM_SHARED_BIT] |
			clocked_serial10_event | uart0_transmit_event;
		clr_vec = 28'h0000000;
		for (k = 0; k < `IFM_NSRC; k = k + 1)
			if (ack_valid && ack_index == k[4:0])
				clr_vec[k] = 1'b1;
	end
	// ****************
	// write strobes per byte
	// ****************
	wire [15:0] base = {mem_addr[15:1], 1'b0};
	wire [7:0] bitmask = 8'h01 << mem_bit_pos;
	wire [7:0] lo_bits = mem_bit ? bitmask : 8'hFF;
	wire [7:0] hi_bits = mem_bit ? bitmask : 8'hFF;
	wire [7:0] lo_data = mem_bit ? {8{mem_wdata[0]}} : mem_wdata[7:0];
	wire [7:0] hi_data = mem_bit ? {8{mem_wdata[0]}} :
		(mem_word ? mem_wdata[15:8] : mem_wdata[7:0]);
	reg [11:0] wr_en;
	reg [11:0] wr_hi;
	integer j;
	always @* begin
		wr_en = 12'h000;
		wr_hi = 12'h000;
		for (j = 0; j < 12; j = j + 1) begin
			if (mem_wr && mem_word && !mem_bit &&
				base == `IFM_ADDR_REQ0 + j[15:0] - (j[0] ? 16'h0001 : 16'h0000)) begin
				if (j >= 4)
					wr_en[j] = 1'b1;
				wr_hi[j] = j[0];
			end else if (mem_wr && mem_addr == `IFM_ADDR_REQ0 + j[15:0]) begin
				wr_en[j] = 1'b1;
				wr_hi[j] = 1'b0;
			end
		end
	end
	// ****************
	// register bytes
	// ****************
	wire [7:0] rq [0:3];
	wire [7:0] mk [0:3];
	wire [7:0] pr [0:3];
	ifm_byte_reg #(
		.RESET_VAL(`IFM_RST_REQ),
		.LIVE(8'hFF),
		.FIXED(8'h00)
	) u_req0 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(wr_en[0]),
		.wr_bits(lo_bits),
		.wr_data(lo_data),
		.hw_set(set_vec[7:0]),
		.hw_clr(clr_vec[7:0]),
		.value(rq[0])
	);
	ifm_byte_reg #(
		.RESET_VAL(`IFM_RST_REQ),
		.LIVE(8'hFF),
		.FIXED(8'h00)
	) u_req1 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(wr_en[1]),
		.wr_bits(lo_bits),
		.wr_data(lo_data),
		.hw_set(set_vec[15:8]),
		.hw_clr(clr_vec[15:8]),
		.value(rq[1])
	);
	ifm_byte_reg #(
		.RESET_VAL(`IFM_RST_REQ),
		.LIVE(8'hFF),
		.FIXED(8'h00)
	) u_req2 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(wr_en[2]),
		.wr_bits(lo_bits),
		.wr_data(lo_data),
		.hw_set(set_vec[23:16]),
		.hw_clr(clr_vec[23:16]),
		.value(rq[2])
	);
	ifm_byte_reg #(
		.RESET_VAL(`IFM_RST_REQ),
		.LIVE(`IFM_REQ3_LIVE),
		.FIXED(8'h00)
	) u_req3 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(wr_en[3]),
		.wr_bits(lo_bits),
		.wr_data(lo_data),
		.hw_set({4'h0, set_vec[27:24]}),
		.hw_clr({4'h0, clr_vec[27:24]}),
		.value(rq[3])
	);
	ifm_byte_reg #(
		.RESET_VAL(`IFM_RST_MSK),
		.LIVE(8'hFF),
		.FIXED(8'h00)
	) u_msk0 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(wr_en[4]),
		.wr_bits(lo_bits),
		.wr_data(lo_data),
		.hw_set(8'h00),
		.hw_clr(8'h00),
		.value(mk[0])
	);
	ifm_byte_reg #(
		.RESET_VAL(`IFM_RST_MSK),
		.LIVE(8'hFF),
		.FIXED(8'h00)
	) u_msk1 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(wr_en[5]),
		.wr_bits(hi_bits),
		.wr_data(wr_hi[5] ? hi_data : lo_data),
		.hw_set(8'h00),
		.hw_clr(8'h00),
		.value(mk[1])
	);
	ifm_byte_reg #(
		.RESET_VAL(`IFM_RST_MSK),
		.LIVE(8'hFF),
		.FIXED(8'h00)
	) u_msk2 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(wr_en[6]),
		.wr_bits(lo_bits),
		.wr_data(lo_data),
		.hw_set(8'h00),
		.hw_clr(8'h00),
		.value(mk[2])
	);
	ifm_byte_reg #(
		.RESET_VAL(`IFM_RST_MSK3),
		.LIVE(`IFM_MSK3_LIVE),
		.FIXED(`IFM_MSK3_FIXED)
	) u_msk3 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(wr_en[7]),
		.wr_bits(hi_bits),
		.wr_data(wr_hi[7] ? hi_data : lo_data),
		.hw_set(8'h00),
		.hw_clr(8'h00),
		.value(mk[3])
	);
	ifm_byte_reg #(
		.RESET_VAL(`IFM_RST_PRI),
		.LIVE(8'hFF),
		.FIXED(8'h00)
	) u_pri0 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(wr_en[8]),
		.wr_bits(lo_bits),
		.wr_data(lo_data),
		.hw_set(8'h00),
		.hw_clr(8'h00),
		.value(pr[0])
	);
	ifm_byte_reg #(
		.RESET_VAL(`IFM_RST_PRI),
		.LIVE(8'hFF),
		.FIXED(8'h00)
	) u_pri1 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(wr_en[9]),
		.wr_bits(hi_bits),
		.wr_data(wr_hi[9] ? hi_data : lo_data),
		.hw_set(8'h00),
		.hw_clr(8'h00),
		.value(pr[1])
	);
	ifm_byte_reg #(
		.RESET_VAL(`IFM_RST_PRI),
		.LIVE(8'hFF),
		.FIXED(8'h00)
	) u_pri2 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(wr_en[10]),
		.wr_bits(lo_bits),
		.wr_data(lo_data),
		.hw_set(8'h00),
		.hw_clr(8'h00),
		.value(pr[2])
	);
	ifm_byte_reg #(
		.RESET_VAL(`IFM_RST_PRI),
		.LIVE(`IFM_PRI3_LIVE),
		.FIXED(`IFM_PRI3_FIXED)
	) u_pri3 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(wr_en[11]),
		.wr_bits(hi_bits),
		.wr_data(wr_hi[11] ? hi_data : lo_data),
		.hw_set(8'h00),
		.hw_clr(8'h00),
		.value(pr[3])
	);
	wire [31:0] req_all = {rq[3], rq[2], rq[1], rq[0]};
	wire [31:0] msk_all = {mk[3], mk[2], mk[1], mk[0]};
	wire [31:0] pri_all = {pr[3], pr[2], pr[1], pr[0]};
	// ****************
	// acknowledge selection
	// ****************
	wire [27:0] eligible = req_all[27:0] & ~msk_all[27:0];
	wire sel_found;
	wire [4:0] sel_index;
	ifm_arbiter #(
		.N(`IFM_NSRC)
	) u_arb (
		.eligible(eligible),
		.prio(pri_all[27:0]),
		.found(sel_found),
		.index(sel_index)
	);
	// ****************
	// read path
	// ****************
	reg [15:0] next_rdata;
	reg [7:0] byte_sel;
	reg [7:0] pair_hi;
	always @* begin
		case (mem_addr)
			`IFM_ADDR_REQ0: byte_sel = rq[0];
			`IFM_ADDR_REQ1: byte_sel = rq[1];
			`IFM_ADDR_REQ2: byte_sel = rq[2];
			`IFM_ADDR_REQ3: byte_sel = rq[3];
			`IFM_ADDR_MSK0: byte_sel = mk[0];
			`IFM_ADDR_MSK1: byte_sel = mk[1];
			`IFM_ADDR_MSK2: byte_sel = mk[2];
			`IFM_ADDR_MSK3: byte_sel = mk[3];
			`IFM_ADDR_PRI0: byte_sel = pr[0];
			`IFM_ADDR_PRI1: byte_sel = pr[1];
			`IFM_ADDR_PRI2: byte_sel = pr[2];
			`IFM_ADDR_PRI3: byte_sel = pr[3];
			default: byte_sel = 8'h00;
		endcase
		case (base)
			`IFM_ADDR_REQ0: pair_hi = rq[1];
			`IFM_ADDR_REQ2: pair_hi = rq[3];
			`IFM_ADDR_MSK0: pair_hi = mk[1];
			`IFM_ADDR_MSK2: pair_hi = mk[3];
			`IFM_ADDR_PRI0: pair_hi = pr[1];
			`IFM_ADDR_PRI2: pair_hi = pr[3];
			default: pair_hi = 8'h00;
		endcase
		if (!mem_rd)
			next_rdata = mem_rdata;
		else if (mem_word && !mem_addr[0])
			next_rdata = {pair_hi, byte_sel};
		else
			next_rdata = {8'h00, byte_sel};
	end
	// ****************
	// output flops
	// ****************
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_rdata <= 16'h0000;
			irq_pending <= 1'b0;
			irq_index <= 5'h00;
			irq_level <= 1'b1;
		end else begin
			mem_rdata <= next_rdata;
			irq_pending <= sel_found & ~(ack_valid && ack_index == sel_index);
			irq_index <= sel_index;
			irq_level <= pri_all[sel_index];
		end
	end
endmodule

//--- test/ifm_core_model.sv
`timescale 1ns/1ns
// ****
// core acknowledge model
// ****
module ifm_core_model (
	input wire ref_clk,
	input wire en,
	input wire irq_pending,
	input wire [4:0] irq_index,
	output reg ack_valid,
	output reg [4:0] ack_index
);
initial begin
	ack_valid = 1'b0;
	ack_index = 5'h00;
end
always @(negedge ref_clk) begin
	ack_valid <= en && irq_pending && !ack_valid;
	ack_index <= irq_pending ? irq_index : ~ack_index;
end
endmodule

//--- test/ifm_bank_checker.sv
`timescale 1ns/1ns
// ****
// port checks
// ****
module ifm_bank_checker (
	input wire ref_clk,
	input wire rst_n,
	input wire [27:0] src_event,
	input wire clocked_serial10_event,
	input wire uart0_transmit_event,
	input wire ack_valid,
	input wire [4:0] ack_index,
	input wire mem_wr,
	input wire mem_rd,
	input wire [15:0] mem_addr,
	input wire mem_word,
	input wire mem_bit,
	input wire [2:0] mem_bit_pos,
	input wire [15:0] mem_wdata,
	input wire [15:0] mem_rdata,
	input wire irq_pending,
	input wire [4:0] irq_index,
	input wire irq_level
);
wire rb = mem_rd & ~mem_word;
wire quiet = !clocked_serial10_event && !uart0_transmit_event && src_event == 28'h0;
default clocking @(posedge ref_clk);
endclocking
default disable iff (!rst_n);
a_rst_out: assert property ($rose(rst_n) |-> !irq_pending && irq_level)
	else $error("reset outputs");
a_rd_upper: assert property (rb |=> mem_rdata[15:8] == 8'h00)
	else $error("upper byte");
a_rd_hold: assert property (!mem_rd |=> $stable(mem_rdata))
	else $error("rdata moved");
a_unmapped_rd: assert property (mem_rd && mem_addr > 16'hFFEB |=> mem_rdata == 16'h0000)
	else $error("unmapped read");
a_flag3_top: assert property (rb && mem_addr == 16'hFFE3 |=> mem_rdata[7:4] == 4'h0)
	else $error("flag3 top");
a_mask3_top: assert property (rb && mem_addr == 16'hFFE7 |=> mem_rdata[7:4] == 4'hD)
	else $error("mask3 top");
a_pri3_top: assert property (rb && mem_addr == 16'hFFEB |=> mem_rdata[7:4] == 4'hF)
	else $error("pri3 top");
a_idx_range: assert property (irq_pending |-> irq_index < 5'd28)
	else $error("index range");
a_ack_drop: assert property (ack_valid && irq_pending && ack_index == irq_index && quiet
	&& !mem_wr |=> ##1 (!irq_pending || irq_index != $past(irq_index, 2)))
	else $error("ack kept");
endmodule
bind ifm_bank ifm_bank_checker ifm_bank_checker_inst (.*);

//--- test/tb_ifm_bank.sv
`timescale 1ns/1ns
// ****
// bench
// ****
module tb_ifm_bank;
reg ref_clk = 0, rst_n = 0, wr = 0, rd = 0, wd = 0, bt = 0, en = 0, s10 = 0, u0 = 0;
reg [27:0] ev = 0;
reg [15:0] a = 0, d = 0;
reg [2:0] bp = 0;
reg [7:0] r [0:11];
wire [15:0] q;
wire pend, lvl, av;
wire [4:0] idx, ai;
integer mismatches = 0, checks = 0, cyc = 0, i, w, t;
always #10 ref_clk = ~ref_clk;
ifm_bank ifm_bank_inst (.ref_clk(ref_clk), .rst_n(rst_n), .src_event(ev),
	.clocked_serial10_event(s10), .uart0_transmit_event(u0), .ack_valid(av),
	.ack_index(ai), .mem_wr(wr), .mem_rd(rd), .mem_addr(a), .mem_word(wd), .mem_bit(bt),
	.mem_bit_pos(bp), .mem_wdata(d), .mem_rdata(q), .irq_pending(pend), .irq_index(idx),
	.irq_level(lvl));
ifm_core_model ifm_core_model_inst (.ref_clk(ref_clk), .en(en), .irq_pending(pend),
	.irq_index(idx), .ack_valid(av), .ack_index(ai));
task summarize; begin
	$display("checks %0d mismatches %0d", checks, mismatches);
	if (mismatches == 0 && checks > 0)
		$display("verification passed");
	else
		$display("verification failed");
	$finish;
end endtask
task chk(input [15:0] s, input [15:0] e); begin
	checks = checks + 1;
	if (s !== e) begin
		mismatches = mismatches + 1;
		$display("[ERR] at %h exp %h got %h", a, e, s);
	end
end endtask
function [7:0] fx(input integer i, input [7:0] v);
	fx = i == 3 ? v & 8'h0F : i == 7 ? v & 8'h0F | 8'hD0 : i == 11 ? v | 8'hF0 : v;
endfunction
task op(input w_, input wd_, input integer i, input [15:0] v); begin
	wr = w_;
	rd = !w_;
	wd = wd_;
	a = 16'hFFE0 + i[15:0];
	d = v;
	@(negedge ref_clk);
	wr = 0;
	rd = 0;
	wd = 0;
	@(negedge ref_clk);
end endtask
task wb(input integer i, input [7:0] v); begin
	op(1, 0, i, {8'h00, v});
	r[i] = fx(i, v);
end endtask
task rc(input integer i); begin
	op(0, 0, i, 0);
	chk(q, i < 12 ? {8'h00, r[i]} : 16'h0000);
end endtask
task rw(input integer i); begin
	op(0, 1, i, 0);
	chk(q, {r[i + 1], r[i]});
end endtask
always @(posedge ref_clk) begin
	cyc = cyc + 1;
	if (cyc > 3000) begin
		mismatches = mismatches + 1;
		summarize;
	end
end
initial begin
	w = $urandom(32'h05618C4F);
	for (i = 0; i < 12; i = i + 1) r[i] = i < 4 ? 8'h00 : 8'hFF;
	r[7] = 8'hDF;
	repeat (6) @(negedge ref_clk);
	rst_n = 1;
	@(negedge ref_clk);
	for (i = 0; i < 13; i = i + 1) rc(i);
	t = $urandom;
	ev = t[27:0];
	s10 = 1;
	@(negedge ref_clk);
	ev = 0;
	s10 = 0;
	for (i = 0; i < 28; i = i + 1) if (t[i]) r[i / 8][i % 8] = 1'b1;
	r[1][2] = 1'b1;
	rw(0);
	rw(2);
	chk({15'h0, pend}, 16'h0000);
	for (i = 0; i < 12; i = i + 2) begin
		w = $urandom;
		w[15:8] = fx(i + 1, w[15:8]);
		op(1, 1, i, w[15:0]);
		if (i > 2) {r[i + 1], r[i]} = w[15:0];
		rw(i);
	end
	for (i = 4; i < 12; i = i + 1) wb(i, fx(i, $urandom));
	ev = 28'h0000002;
	wr = 1;
	a = 16'hFFE0;
	d = 16'h0000;
	@(negedge ref_clk);
	ev = 0;
	wr = 0;
	r[0] = 8'h02;
	@(negedge ref_clk);
	rc(0);
	bt = 1;
	bp = 3'd5;
	wb(2, 8'h01);
	r[2] = 8'h20 | t[23:16];
	bp = 3'd1;
	wb(0, 8'h00);
	bt = 0;
	rc(0);
	rc(2);
	for (i = 4; i < 8; i = i + 1) wb(i, fx(i, 8'h00));
	@(negedge ref_clk);
	w = 99;
	for (i = 27; i >= 0; i = i - 1) if (r[i / 8][i % 8] & !r[4 + i / 8][i % 8]) begin
		if (w == 99 || !r[8 + i / 8][i % 8] || r[8 + w / 8][w % 8]) w = i;
	end
	chk({9'h0, pend, lvl, idx}, {9'h0, 1'b1, r[8 + w / 8][w % 8], w[4:0]});
	en = 1;
	w = 0;
	for (i = 0; i < 200 && w < 3; i = i + 1) begin
		@(negedge ref_clk);
		w = pend === 1'b0 ? w + 1 : 0;
	end
	en = 0;
	for (i = 0; i < 4; i = i + 1) r[i] = 8'h00;
	rw(0);
	rw(2);
	ev = 28'h0010000;
	@(negedge ref_clk);
	ev = 0;
	bt = 1;
	bp = 3'd0;
	wb(2, 8'h00);
	bt = 0;
	rc(2);
	summarize;
end
endmodule
